// ---- pkg/rss_pkg.sv ----
// Constants and types of the regulator start-up sequencer
package rss_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned PHASES      = 8;
  localparam int unsigned CODE_W      = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned SYNC_WAIT   = 2;

  // ----------------------------------------------------------------
  // Serial addresses and thresholds (thresholds in 1/16 V units)
  // ----------------------------------------------------------------
  localparam logic [6:0] TEST_BUS_ADDR   = 7'h0A;
  localparam logic [7:0] VIN_THR_MIN     = 8'h48;  // 4.5 V
  localparam logic [7:0] VIN_THR_MAX     = 8'hD3;  // 13.1875 V
  localparam logic [1:0] SYNC_WAIT_CNT   = 2'h2;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RSS_MODE_VENDOR_A = 3'b000,
    RSS_MODE_VENDOR_B = 3'b001,
    RSS_MODE_VENDOR_C = 3'b010,
    RSS_MODE_VENDOR_D = 3'b011,
    RSS_MODE_MEMORY   = 3'b100
  } rss_mode_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RSS_ST_STRAP  = 3'b000,
    RSS_ST_LOAD   = 3'b001,
    RSS_ST_TRIM   = 3'b010,
    RSS_ST_DETECT = 3'b011,
    RSS_ST_IDLE   = 3'b100,
    RSS_ST_RUN    = 3'b101,
    RSS_ST_RAMP   = 3'b110,
    RSS_ST_HALT   = 3'b111
  } rss_state_t;

  // ----------------------------------------------------------------
  // Working configuration word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic       enable_active_low;
    logic       phase_detect_en;
    logic [6:0] bus_addr;
    logic [7:0] vin_on_thr;
    logic [7:0] vin_off_thr;
  } rss_cfg_t;

  localparam rss_cfg_t CFG_RESET = '{mode: 3'h0, enable_active_low: 1'b0, phase_detect_en: 1'b0,
                                     bus_addr: 7'h00, vin_on_thr: 8'h48, vin_off_thr: 8'h48};

endpackage : rss_pkg

// ---- verification/rss_host_model.sv ----
// Model of the configuration store and trim engine beside the sequencer
`timescale 1ns/1ps
module rss_host_model
  import rss_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     reset_n,
  input  wire logic     slow,
  input  wire rss_cfg_t cfg_in,
  input  wire logic     parity_in,
  input  wire logic     nv_load_req,
  output logic          nv_load_done,
  output rss_cfg_t      nv_cfg_word,
  output logic          nv_parity_err,
  input  wire logic     trim_start,
  output logic          trim_done
);
  logic [3:0] load_cnt_reg;
  logic [3:0] trim_cnt_reg;
  logic       trim_pend_reg;
  logic [3:0] wait_len;

  assign wait_len = slow ? 4'h6 : 4'h1;

  // Thresholds never handed over below 4.5 V
  function automatic rss_cfg_t legal(input rss_cfg_t c);
    rss_cfg_t r;
    r = c;
    if (r.vin_on_thr < VIN_THR_MIN) r.vin_on_thr = VIN_THR_MIN;
    if (r.vin_off_thr < VIN_THR_MIN) r.vin_off_thr = VIN_THR_MIN;
    return r;
  endfunction : legal

  // Store answers a load request; word toggles while not valid
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_cnt_reg  <= 4'h0;
      nv_load_done  <= 1'b0;
      nv_cfg_word   <= '0;
      nv_parity_err <= 1'b0;
    end else begin
      nv_load_done  <= 1'b0;
      nv_cfg_word   <= ~nv_cfg_word;
      nv_parity_err <= ~nv_parity_err;
      if (nv_load_req && !nv_load_done) begin
        load_cnt_reg <= load_cnt_reg + 4'h1;
        if (load_cnt_reg == wait_len) begin
          load_cnt_reg  <= 4'h0;
          nv_load_done  <= 1'b1;
          nv_cfg_word   <= legal(cfg_in);
          nv_parity_err <= parity_in;
        end
      end
    end
  end

  // Trim engine answers trim_start after the chosen delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_cnt_reg  <= 4'h0;
      trim_pend_reg <= 1'b0;
      trim_done     <= 1'b0;
    end else begin
      trim_done <= 1'b0;
      if (trim_start) trim_pend_reg <= 1'b1;
      if (trim_pend_reg) begin
        trim_cnt_reg <= trim_cnt_reg + 4'h1;
        if (trim_cnt_reg == wait_len) begin
          trim_cnt_reg  <= 4'h0;
          trim_pend_reg <= 1'b0;
          trim_done     <= 1'b1;
        end
      end
    end
  end
endmodule : rss_host_model

// ---- verification/rss_sequencer_bench.sv ----
// Self-checking bench of the regulator start-up sequencer
`timescale 1ns/1ps
module rss_sequencer_bench;
  import rss_pkg::*;
  localparam rss_cfg_t CFG_A = '{mode: 3'h2, enable_active_low: 1'b1, phase_detect_en: 1'b1,
                                 bus_addr: 7'h31, vin_on_thr: 8'hA0, vin_off_thr: 8'h80};
  localparam rss_cfg_t CFG_B = '{mode: 3'h4, enable_active_low: 1'b0, phase_detect_en: 1'b0,
                                 bus_addr: 7'h22, vin_on_thr: 8'h50, vin_off_thr: 8'h48};
  logic sys_clk, reset_n, address_protect_pin, enable_pin, logic_supply_ok, fault_active;
  logic [7:0] pwm_sense_low, input_rail_sense, aux_rail_sense, loop1_target, loop2_target;
  logic input_rail_strobe, aux_rail_strobe, nv_load_req, nv_load_done, nv_parity_err, trim_start;
  logic trim_done, cfg_wr_valid, ramp_done, pwm_oe_n, soft_start, regulator_ready_output;
  logic ramp_down_req, test_mode, config_loaded, input_rail_valid, slow, parity_in;
  logic [7:0] populated_phases, aux_rail_telemetry;
  logic [6:0] bus_address;
  logic [2:0] active_mode;
  rss_cfg_t nv_cfg_word, cfg_wr_data, cfg_in;
  int err_count, n_compared, cycles;

  rss_sequencer u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .address_protect_pin(address_protect_pin),
    .enable_pin(enable_pin), .logic_supply_ok(logic_supply_ok), .fault_active(fault_active),
    .pwm_sense_low(pwm_sense_low), .input_rail_sense(input_rail_sense), .input_rail_strobe(input_rail_strobe),
    .aux_rail_sense(aux_rail_sense), .aux_rail_strobe(aux_rail_strobe), .nv_load_req(nv_load_req),
    .nv_load_done(nv_load_done), .nv_cfg_word(nv_cfg_word), .nv_parity_err(nv_parity_err),
    .trim_start(trim_start), .trim_done(trim_done), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data),
    .loop1_target(loop1_target), .ramp_done(ramp_done), .pwm_oe_n(pwm_oe_n), .soft_start(soft_start),
    .regulator_ready_output(regulator_ready_output), .ramp_down_req(ramp_down_req),
    .populated_phases(populated_phases), .loop2_target(loop2_target), .bus_address(bus_address),
    .test_mode(test_mode), .config_loaded(config_loaded), .active_mode(active_mode),
    .input_rail_valid(input_rail_valid), .aux_rail_telemetry(aux_rail_telemetry));

  rss_host_model u_host (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .cfg_in(cfg_in),
    .parity_in(parity_in), .nv_load_req(nv_load_req), .nv_load_done(nv_load_done),
    .nv_cfg_word(nv_cfg_word), .nv_parity_err(nv_parity_err), .trim_start(trim_start), .trim_done(trim_done));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic rail(input logic [7:0] v);
    @(posedge sys_clk);
    input_rail_sense  <= v;
    input_rail_strobe <= 1'b1;
    @(posedge sys_clk);
    input_rail_strobe <= 1'b0;
    #1;
  endtask : rail
  task automatic do_reset(input logic prot, input rss_cfg_t c, input logic par, input logic sl);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    address_protect_pin <= prot;
    cfg_in <= c;
    parity_in <= par;
    slow <= sl;
    enable_pin <= c.enable_active_low;
    tick(4);
    check(pwm_oe_n, 1'b1);
    check(populated_phases, 8'hFF);
    @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic wait_loaded();
    int k;
    for (k = 0; k < 40 && config_loaded !== 1'b1; k++) tick(1);
    check(config_loaded, 1'b1);
    check(trim_start, 1'b1);
    check(nv_load_req, 1'b0);
  endtask : wait_loaded
  task automatic start_run();
    int k;
    @(posedge sys_clk);
    enable_pin <= 1'b0;
    for (k = 0; k < 8 && soft_start !== 1'b1; k++) tick(1);
    check(soft_start, 1'b1);
    check(pwm_oe_n, 1'b0);
    tick(1);
    check(regulator_ready_output, 1'b1);
  endtask : start_run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic boot_detect_run();
    int k;
    do_reset(1'b0, CFG_A, 1'b0, 1'b1);
    wait_loaded();
    check(active_mode, RSS_MODE_VENDOR_C);
    tick(14);
    check(bus_address, 7'h31);
    rail(8'hA0);
    check(input_rail_valid, 1'b0);
    rail(8'hA1);
    check(input_rail_valid, 1'b1);
    tick(2);
    check(populated_phases, 8'hF3);
    check(pwm_oe_n, 1'b1);
    pwm_sense_low <= 8'hFF;
    check(loop2_target, 8'h6B);
    start_run();
    check(populated_phases, 8'hF3);
    rail(8'h80);
    check(input_rail_valid, 1'b1);
    check(regulator_ready_output, 1'b1);
  endtask : boot_detect_run
  task automatic rewrite_and_stop();
    rss_cfg_t c;
    c = CFG_A;
    c.mode = RSS_MODE_MEMORY;
    @(posedge sys_clk);
    cfg_wr_valid <= 1'b1;
    cfg_wr_data  <= c;
    @(posedge sys_clk);
    cfg_wr_valid <= 1'b0;
    tick(2);
    check(active_mode, RSS_MODE_MEMORY);
    check(loop2_target, 8'h35);
    @(posedge sys_clk);
    enable_pin <= 1'b1;
    tick(4);
    check(regulator_ready_output, 1'b0);
    check(ramp_down_req, 1'b1);
    check(pwm_oe_n, 1'b0);
    @(posedge sys_clk);
    ramp_done <= 1'b1;
    @(posedge sys_clk);
    ramp_done <= 1'b0;
    tick(1);
    check(pwm_oe_n, 1'b1);
  endtask : rewrite_and_stop
  task automatic rail_loss_and_aux();
    start_run();
    rail(8'h7F);
    check(input_rail_valid, 1'b0);
    tick(1);
    check(pwm_oe_n, 1'b1);
    check(ramp_down_req, 1'b0);
    @(posedge sys_clk);
    aux_rail_sense  <= 8'h5C;
    aux_rail_strobe <= 1'b1;
    @(posedge sys_clk);
    aux_rail_strobe <= 1'b0;
    tick(1);
    check(aux_rail_telemetry, 8'h5C);
    // Rail back but a fault holds the start off
    fault_active <= 1'b1;
    rail(8'hFF);
    tick(4);
    check(soft_start, 1'b0);
    check(pwm_oe_n, 1'b1);
    fault_active <= 1'b0;
    start_run();
  endtask : rail_loss_and_aux
  task automatic test_mode_load();
    do_reset(1'b1, CFG_B, 1'b0, 1'b0);
    tick(14);
    check(test_mode, 1'b1);
    check(bus_address, TEST_BUS_ADDR);
    check(nv_load_req, 1'b0);
    check(config_loaded, 1'b0);
    address_protect_pin <= 1'b0;
    wait_loaded();
    check(active_mode, RSS_MODE_MEMORY);
  endtask : test_mode_load
  task automatic parity_halt();
    do_reset(1'b0, CFG_B, 1'b1, 1'b0);
    tick(20);
    rail(8'hFF);
    enable_pin <= 1'b1;
    tick(10);
    check(pwm_oe_n, 1'b1);
    check(regulator_ready_output, 1'b0);
  endtask : parity_halt

  initial begin
    reset_n = 1'b0;
    address_protect_pin = 1'b0;
    enable_pin = 1'b1;
    logic_supply_ok = 1'b1;
    fault_active = 1'b0;
    pwm_sense_low = 8'h0C;
    input_rail_sense = 8'h00;
    input_rail_strobe = 1'b0;
    aux_rail_sense = 8'h00;
    aux_rail_strobe = 1'b0;
    cfg_wr_valid = 1'b0;
    cfg_wr_data = CFG_A;
    loop1_target = 8'h6B;
    ramp_done = 1'b0;
    slow = 1'b0;
    parity_in = 1'b0;
    cfg_in = CFG_A;
    boot_detect_run();
    rewrite_and_stop();
    rail_loss_and_aux();
    test_mode_load();
    parity_halt();
    results();
  end
endmodule : rss_sequencer_bench

// ---- verilog/rss_sequencer.sv ----
// Start-up, enable and input-rail qualification sequencer of the regulator controller
//
// What this block does
// - Operating mode comes only from the working configuration mode field, as loaded or as rewritten over the serial bus.
// - Memory mode drives loop two target at half of loop one target.
// - Pulse-width outputs stay high impedance until soft-start begins.
// - After reset, copy configuration first, then run trim.
// - With detection on and rail valid, low-sensed pins mark unpopulated phases.
// - Serial bus rewrites of working registers accepted once loading completed.
// - Protect pin high through reset selects test mode, address 0Ah.
// - Test mode postpones configuration copy until protect pin goes low.
// - Enable starts outputs and soft-start only with both supplies good.
// - A configuration bit selects enable polarity.
// - Enable deactivation drops regulator ready and shuts regulator down.
// - Rail thresholds clamped to no less than 4.5 V; no upper clamp at 13.1875 V, any code up to 0FFh is used.
// - Outputs activate when rising rail sense crosses turn-on with enable.
// - Rail stays valid until sense falls below the turn-off threshold.
// - Auxiliary rail reported as an 8-bit read-only code.
// - Start needs supplies, enable, no faults, no configuration parity error.
// - Enable deactivation ramps both loops down instead of cutting off.
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               address_protect_pin,
  input  wire logic               enable_pin,
  input  wire logic               logic_supply_ok,
  input  wire logic               fault_active,
  input  wire logic [PHASES-1:0]  pwm_sense_low,
  input  wire logic [7:0]         input_rail_sense,
  input  wire logic               input_rail_strobe,
  input  wire logic [7:0]         aux_rail_sense,
  input  wire logic               aux_rail_strobe,
  output logic                    nv_load_req,
  input  wire logic               nv_load_done,
  input  wire rss_cfg_t           nv_cfg_word,
  input  wire logic               nv_parity_err,
  output logic                    trim_start,
  input  wire logic               trim_done,
  input  wire logic               cfg_wr_valid,
  input  wire rss_cfg_t           cfg_wr_data,
  input  wire logic [7:0]         loop1_target,
  input  wire logic               ramp_done,
  output logic                    pwm_oe_n,
  output logic                    soft_start,
  output logic                    regulator_ready_output,
  output logic                    ramp_down_req,
  output logic [PHASES-1:0]       populated_phases,
  output logic [7:0]              loop2_target,
  output logic [6:0]              bus_address,
  output logic                    test_mode,
  output logic                    config_loaded,
  output logic [2:0]              active_mode,
  output logic                    input_rail_valid,
  output logic [7:0]              aux_rail_telemetry
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PHASES+3:0] sync1_reg;
  logic [PHASES+3:0] sync2_reg;

  // Two flops on every pin-level input
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {pwm_sense_low, fault_active, logic_supply_ok, enable_pin, address_protect_pin};
      sync2_reg <= sync1_reg;
    end
  end

  logic              ap_s;
  logic              en_s;
  logic              vcc_s;
  logic              fault_s;
  logic [PHASES-1:0] low_s;
  assign ap_s    = sync2_reg[0];
  assign en_s    = sync2_reg[1];
  assign vcc_s   = sync2_reg[2];
  assign fault_s = sync2_reg[3];
  assign low_s   = sync2_reg[PHASES+3:4];

  // ----------------------------------------------------------------
  // State and working registers
  // ----------------------------------------------------------------
  rss_state_t        state_reg;
  rss_cfg_t          cfg_reg;
  logic [1:0]        strap_cnt_reg;
  logic              loaded_reg;
  logic              parity_bad_reg;
  logic              test_mode_reg;
  logic              vin_valid_reg;
  logic              pwm_oe_n_reg;
  logic              soft_start_reg;
  logic              ready_reg;
  logic              ramp_req_reg;
  logic              load_req_reg;
  logic              trim_start_reg;
  logic [PHASES-1:0] phases_reg;
  logic [7:0]        loop2_reg;
  logic [7:0]        aux_reg;
  logic              enable_act;
  logic              start_ok;
  logic [7:0]        on_thr;
  logic [7:0]        off_thr;

  // Polarity-corrected enable
  assign enable_act = en_s ^ cfg_reg.enable_active_low;
  // Thresholds clamped to the legal floor
  assign on_thr  = (cfg_reg.vin_on_thr  < VIN_THR_MIN) ? VIN_THR_MIN : cfg_reg.vin_on_thr;
  assign off_thr = (cfg_reg.vin_off_thr < VIN_THR_MIN) ? VIN_THR_MIN : cfg_reg.vin_off_thr;
  // All start conditions together
  assign start_ok = vcc_s && vin_valid_reg && enable_act && !fault_s && !parity_bad_reg;

  // ----------------------------------------------------------------
  // Strap capture of the protect pin after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_reg <= 2'h0;
      test_mode_reg <= 1'b0;
    end else if (state_reg == RSS_ST_STRAP) begin
      if (strap_cnt_reg == SYNC_WAIT_CNT) begin
        test_mode_reg <= ap_s;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= RSS_ST_STRAP;
    end else begin
      unique case (state_reg)
        RSS_ST_STRAP: begin
          if (strap_cnt_reg == SYNC_WAIT_CNT) begin
            state_reg <= RSS_ST_LOAD;
          end
        end
        RSS_ST_LOAD: begin
          if (nv_load_done) begin
            state_reg <= nv_parity_err ? RSS_ST_HALT : RSS_ST_TRIM;
          end
        end
        RSS_ST_TRIM: begin
          if (trim_done) begin
            state_reg <= cfg_reg.phase_detect_en ? RSS_ST_DETECT : RSS_ST_IDLE;
          end
        end
        RSS_ST_DETECT: begin
          if (vin_valid_reg) begin
            state_reg <= RSS_ST_IDLE;
          end
        end
        RSS_ST_IDLE: begin
          if (start_ok) begin
            state_reg <= RSS_ST_RUN;
          end
        end
        RSS_ST_RUN: begin
          if (!vin_valid_reg || !vcc_s || fault_s) begin
            state_reg <= RSS_ST_IDLE;
          end else if (!enable_act) begin
            state_reg <= RSS_ST_RAMP;
          end
        end
        RSS_ST_RAMP: begin
          if (ramp_done || !vin_valid_reg) begin
            state_reg <= RSS_ST_IDLE;
          end
        end
        RSS_ST_HALT: begin
          state_reg <= RSS_ST_HALT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration transfer request and load
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_req_reg   <= 1'b0;
      loaded_reg     <= 1'b0;
      parity_bad_reg <= 1'b0;
      cfg_reg        <= CFG_RESET;
    end else begin
      // Held back while test mode keeps the protect pin high
      load_req_reg <= (state_reg == RSS_ST_LOAD) && !nv_load_done && !(test_mode_reg && ap_s);
      if (state_reg == RSS_ST_LOAD && nv_load_done) begin
        cfg_reg        <= nv_cfg_word;
        loaded_reg     <= 1'b1;
        parity_bad_reg <= nv_parity_err;
      end else if (loaded_reg && cfg_wr_valid) begin
        cfg_reg <= cfg_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim start pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_start_reg <= 1'b0;
    end else begin
      trim_start_reg <= (state_reg == RSS_ST_LOAD) && nv_load_done && !nv_parity_err;
    end
  end

  // ----------------------------------------------------------------
  // Input rail qualification with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vin_valid_reg <= 1'b0;
    end else if (input_rail_strobe) begin
      if (!vin_valid_reg && input_rail_sense > on_thr) begin
        vin_valid_reg <= 1'b1;
      end else if (vin_valid_reg && input_rail_sense < off_thr) begin
        vin_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase detection, latched until power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phases_reg <= {PHASES{1'b1}};
    end else if (state_reg == RSS_ST_DETECT && vin_valid_reg) begin
      phases_reg <= ~low_s;
    end
  end

  // ----------------------------------------------------------------
  // Output stage control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_oe_n_reg   <= 1'b1;
      soft_start_reg <= 1'b0;
      ready_reg      <= 1'b0;
      ramp_req_reg   <= 1'b0;
    end else begin
      // Drive only while running or ramping down
      pwm_oe_n_reg   <= !((state_reg == RSS_ST_IDLE && start_ok) ||
                          (state_reg == RSS_ST_RUN && vin_valid_reg && vcc_s && !fault_s) ||
                          (state_reg == RSS_ST_RAMP && vin_valid_reg && !ramp_done));
      soft_start_reg <= (state_reg == RSS_ST_IDLE) && start_ok;
      ready_reg      <= (state_reg == RSS_ST_RUN) && enable_act && vin_valid_reg && vcc_s && !fault_s;
      ramp_req_reg   <= (state_reg == RSS_ST_RUN && !enable_act && vin_valid_reg && vcc_s && !fault_s) ||
                        (state_reg == RSS_ST_RAMP && !ramp_done && vin_valid_reg);
    end
  end

  // ----------------------------------------------------------------
  // Loop two target and auxiliary telemetry
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop2_reg <= 8'h00;
    end else if (cfg_reg.mode == RSS_MODE_MEMORY) begin
      loop2_reg <= {1'b0, loop1_target[7:1]};
    end else begin
      loop2_reg <= loop1_target;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_reg <= 8'h00;
    end else if (aux_rail_strobe) begin
      aux_reg <= aux_rail_sense;
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign nv_load_req            = load_req_reg;
  assign trim_start             = trim_start_reg;
  assign pwm_oe_n               = pwm_oe_n_reg;
  assign soft_start             = soft_start_reg;
  assign regulator_ready_output = ready_reg;
  assign ramp_down_req          = ramp_req_reg;
  assign populated_phases       = phases_reg;
  assign loop2_target           = loop2_reg;
  assign test_mode              = test_mode_reg;
  assign config_loaded          = loaded_reg;
  assign input_rail_valid       = vin_valid_reg;
  assign aux_rail_telemetry     = aux_reg;
  assign active_mode            = cfg_reg.mode;

  logic [6:0] addr_reg;
  // Test mode overrides the configured address
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= TEST_BUS_ADDR;
    end else begin
      addr_reg <= test_mode_reg ? TEST_BUS_ADDR : cfg_reg.bus_addr;
    end
  end
  assign bus_address = addr_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_load_done;
    state_reg == RSS_ST_LOAD && nv_load_done && !nv_parity_err;
  endsequence

  sequence seq_trim_go;
    ##1 trim_start && state_reg == RSS_ST_TRIM;
  endsequence

  AST_LOAD_THEN_TRIM: assert property (@(posedge sys_clk) disable iff (!reset_n)
    seq_load_done |-> seq_trim_go)
    else $error("trim did not follow configuration load");

  AST_HIZ_BEFORE_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pwm_oe_n |-> $past(state_reg) inside {RSS_ST_IDLE, RSS_ST_RUN, RSS_ST_RAMP} && config_loaded)
    else $error("outputs driven before soft-start");

  AST_TEST_ADDR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    test_mode |=> bus_address == TEST_BUS_ADDR)
    else $error("test mode address wrong");

  AST_TEST_HOLD_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    test_mode && ap_s && state_reg == RSS_ST_LOAD |=> !nv_load_req)
    else $error("configuration load requested in test mode");

  AST_START_COND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(soft_start) |-> $past(vcc_s) && $past(vin_valid_reg) && $past(enable_act) && !$past(fault_s))
    else $error("soft-start without start conditions");

  AST_READY_DROP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == RSS_ST_RUN && !enable_act && vin_valid_reg && vcc_s && !fault_s |=>
      !regulator_ready_output && ramp_down_req)
    else $error("ready held after enable removed");

  AST_MEMORY_HALF: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_reg.mode == RSS_MODE_MEMORY && $stable(cfg_reg.mode) |=> loop2_target == {1'b0, $past(loop1_target[7:1])})
    else $error("memory mode loop two target not half");

  AST_HYST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    vin_valid_reg && input_rail_strobe && input_rail_sense >= off_thr |=> vin_valid_reg)
    else $error("rail dropped above turn-off");

  AST_PHASE_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg != RSS_ST_DETECT |=> $stable(populated_phases))
    else $error("phase result changed after detection");

  AST_AUX_CAPTURE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    aux_rail_strobe |=> aux_rail_telemetry == $past(aux_rail_sense))
    else $error("auxiliary telemetry not updated");

endmodule : rss_sequencer
